// [logic/rtcp_pkg.sv]
// Purpose: Shared constants and carrier types for the time-base prescaler block
// Assumes: 200 MHz system clock, internal time base of 8192 Hz
// Notes:   Control bits arrive as plain ports grouped in one struct
package rtcp_pkg;

    // System and time-base rates
    localparam int CLK_HZ         = 200_000_000;
    localparam int TB_HZ          = 8192;
    localparam int INT_DIV        = CLK_HZ / TB_HZ;

    // Prescaler geometry
    localparam int PRESC_W        = 13;
    localparam logic [12:0] PRESC_RST     = 13'h0000;
    localparam logic [12:0] SEC_LAST      = 13'h1FFF;  // 8192 edges per second
    localparam logic [12:0] FIRST_SEC_HUN = 13'h1FEF;  // 8176 edges to first second

    // Hundredths generation
    localparam logic [6:0]  FIRST_HUN     = 7'h50;     // 80 edges
    localparam logic [6:0]  HUN_LONG      = 7'h60;     // three 256 Hz periods
    localparam logic [6:0]  HUN_SHORT     = 7'h40;     // two 256 Hz periods
    localparam int          DITHER_LEN    = 24;
    localparam logic [23:0] DITHER_PAT    = 24'hD56AAA; // leftmost bit first
    localparam logic [4:0]  DITHER_LAST   = 5'h17;

    // Clock output selection
    localparam logic [2:0]  FREQ_TEST     = 3'h7;
    localparam logic [7:0]  CLKDIV_RST    = 8'h00;

    typedef struct packed {
        logic       halt;
        logic       prescaler_clear;
        logic       hundredths_enable;
        logic       external_clock_test_enable;
        logic [2:0] clock_out_pin_freq_select;
    } rtcp_ctrl_t;

    typedef struct packed {
        logic second_tick;
        logic hundredth_tick;
    } rtcp_ticks_t;

endpackage : rtcp_pkg

// [logic/rtcp_prescaler.sv]
// Purpose: Time-base prescaler with halt, prescaler clear and external clock test mode
// Assumes: Control bits come from register logic on sys_clk; clock pin is asynchronous
// Notes:   Ticks are one-cycle pulses on sys_clk that step the calendar counters
// Behaviour
// - Test mode when frequency select is 111 and test enable set; pin turns input.
// - In test mode pin edges replace internal 8192 Hz; 8192 edges make a second.
// - Halt plus clear holds prescaler at zero until both bits drop.
// - After halt release first second comes after 8192 edges, then every 8192.
// - Hundredths mode: first hundredth at 80 edges, first second at 8176.
// - Hundredths follow dither pattern at 256 Hz after the first second.
// - Test mode entry is unsynchronised; prescaler state undefined until cleared.
// - Halt stops time counting in normal and test mode.
// - Time and date writes allowed only while halt is set.
// - Halt gates the time base off yet still accepts prescaler clear.
// - Halt does not affect the clock output pin frequencies.
// - First increment within one time-base period after halt release.
module rtcp_prescaler #(
    parameter int INT_DIV_CYCLES = rtcp_pkg::INT_DIV
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    // Control bits
    input  wire rtcp_pkg::rtcp_ctrl_t  ctrl,
    // Clock pin, three signals
    input  wire logic                  clock_out_pin_i,
    output logic                       clock_out_pin_o,
    output logic                       clock_out_pin_oe,
    // Status and ticks
    output logic                       time_write_enable,
    output logic                       test_mode_active,
    output rtcp_pkg::rtcp_ticks_t      ticks
);

    ////////////////////////////////////////////////////////////////////////////////
    // Internal 8192 Hz enable and clock output divider

    logic [15:0] int_cnt;
    logic [15:0] next_int_cnt;
    logic        int_tick;
    logic [7:0]  clkdiv;
    logic [7:0]  next_clkdiv;
    logic        next_clock_out_pin_o;
    logic        test_mode;

    assign test_mode = ctrl.external_clock_test_enable
                       && (ctrl.clock_out_pin_freq_select == rtcp_pkg::FREQ_TEST);
    assign int_tick  = (int_cnt == 16'(INT_DIV_CYCLES - 1));

    always_comb begin
        next_int_cnt = int_tick ? 16'h0000 : int_cnt + 16'h0001;
        next_clkdiv  = int_tick ? clkdiv + 8'h01 : clkdiv;
        // Output runs free of halt so downstream clocks never stall
        next_clock_out_pin_o = clkdiv[ctrl.clock_out_pin_freq_select];
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            int_cnt         <= 16'h0000;
            clkdiv          <= rtcp_pkg::CLKDIV_RST;
            clock_out_pin_o <= 1'b0;
        end else begin
            int_cnt         <= next_int_cnt;
            clkdiv          <= next_clkdiv;
            clock_out_pin_o <= next_clock_out_pin_o;
        end
    end

    assign clock_out_pin_oe = !test_mode;

    ////////////////////////////////////////////////////////////////////////////////
    // External clock pin synchroniser and edge detect

    logic sync1;
    logic sync2;
    logic sync3;
    logic ext_edge;
    logic tb_tick;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= clock_out_pin_i;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign ext_edge = sync2 && !sync3;
    // No resync on mode entry: prescaler keeps whatever it held
    assign tb_tick  = test_mode ? ext_edge : int_tick;

    ////////////////////////////////////////////////////////////////////////////////
    // Halt, clear hold and prescaler chain

    logic        hold;
    logic        next_hold;
    logic        stopped;
    logic        step;
    logic [12:0] presc;
    logic [12:0] next_presc;
    logic        first_done;
    logic        next_first_done;
    logic [6:0]  hcnt;
    logic [6:0]  next_hcnt;
    logic [4:0]  didx;
    logic [4:0]  next_didx;
    logic [6:0]  hun_target;
    logic        sec_hit;
    logic        hun_hit;
    rtcp_pkg::rtcp_ticks_t next_ticks;

    assign stopped = ctrl.halt || hold;
    assign step    = tb_tick && !stopped;
    assign time_write_enable = ctrl.halt;
    assign test_mode_active  = test_mode;

    always_comb begin
        hun_target = !first_done ? rtcp_pkg::FIRST_HUN :
                     (rtcp_pkg::DITHER_PAT[5'(rtcp_pkg::DITHER_LEN - 1) - didx]
                      ? rtcp_pkg::HUN_LONG : rtcp_pkg::HUN_SHORT);
        if (ctrl.hundredths_enable && !first_done) begin
            sec_hit = step && (presc == rtcp_pkg::FIRST_SEC_HUN);
        end else begin
            sec_hit = step && (presc == rtcp_pkg::SEC_LAST);
        end
        hun_hit = ctrl.hundredths_enable && step && (hcnt == hun_target - 7'h01);
    end

    always_comb begin
        next_hold       = hold;
        next_presc      = presc;
        next_first_done = first_done;
        next_hcnt       = hcnt;
        next_didx       = didx;
        next_ticks      = '0;
        if (ctrl.halt && ctrl.prescaler_clear) begin
            next_hold = 1'b1;
        end else if (!ctrl.halt && !ctrl.prescaler_clear) begin
            next_hold = 1'b0;
        end
        if (ctrl.halt && ctrl.prescaler_clear) begin
            // Clear accepted while time base is gated off
            next_presc      = rtcp_pkg::PRESC_RST;
            next_first_done = 1'b0;
            next_hcnt       = 7'h00;
            next_didx       = 5'h00;
        end else if (step) begin
            next_presc = presc + 13'h0001;
            next_hcnt  = hun_hit ? 7'h00 : hcnt + 7'h01;
            if (hun_hit && first_done) begin
                next_didx = (didx == rtcp_pkg::DITHER_LAST) ? 5'h00 : didx + 5'h01;
            end
            if (sec_hit) begin
                if (!first_done && ctrl.hundredths_enable) begin
                    // Realign so later seconds fall every 8192 edges
                    next_presc = rtcp_pkg::PRESC_RST;
                    next_hcnt  = 7'h00;
                    next_didx  = 5'h00;
                end
                next_first_done = 1'b1;
            end
            next_ticks.second_tick    = sec_hit;
            next_ticks.hundredth_tick = hun_hit || (sec_hit && ctrl.hundredths_enable);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hold       <= 1'b0;
            presc      <= rtcp_pkg::PRESC_RST;
            first_done <= 1'b0;
            hcnt       <= 7'h00;
            didx       <= 5'h00;
            ticks      <= '0;
        end else begin
            hold       <= next_hold;
            presc      <= next_presc;
            first_done <= next_first_done;
            hcnt       <= next_hcnt;
            didx       <= next_didx;
            ticks      <= next_ticks;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_clear_cmd;
        ctrl.halt && ctrl.prescaler_clear;
    endsequence

    sequence s_released;
        !ctrl.halt && !hold;
    endsequence

    AST_TEST_PIN_INPUT: assert property (@(posedge sys_clk) disable iff (!nrst)
        (ctrl.external_clock_test_enable && ctrl.clock_out_pin_freq_select == 3'h7)
        |-> !clock_out_pin_oe)
        else $error("Clock pin driven in test mode");

    AST_PIN_BACK_OUT: assert property (@(posedge sys_clk) disable iff (!nrst)
        !ctrl.external_clock_test_enable |-> clock_out_pin_oe)
        else $error("Clock pin not driven outside test mode");

    AST_EXT_EDGE_STEPS: assert property (@(posedge sys_clk) disable iff (!nrst)
        (test_mode && ext_edge && !stopped && !(ctrl.halt && ctrl.prescaler_clear)
         && presc != 13'h1FFF && presc != 13'h1FEF)
        |=> presc == $past(presc) + 13'h0001)
        else $error("External edge did not advance prescaler");

    AST_CLEAR_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_clear_cmd |=> presc == 13'h0000 && hold)
        else $error("Prescaler not cleared by halt and clear");

    AST_HOLD_UNTIL_BOTH_LOW: assert property (@(posedge sys_clk) disable iff (!nrst)
        (hold && (ctrl.halt || ctrl.prescaler_clear)) |=> hold && !ticks.second_tick)
        else $error("Hold released before both bits cleared");

    AST_SECOND_AFTER_8192: assert property (@(posedge sys_clk) disable iff (!nrst)
        (step && presc == 13'h1FFF && !ctrl.hundredths_enable) |=> ticks.second_tick)
        else $error("Missing second tick after 8192 edges");

    AST_FIRST_HUN_80: assert property (@(posedge sys_clk) disable iff (!nrst)
        (step && ctrl.hundredths_enable && !first_done && hcnt == 7'h4F)
        |=> ticks.hundredth_tick ##0 hcnt == 7'h00)
        else $error("First hundredth not at 80 edges");

    AST_FIRST_SEC_8176: assert property (@(posedge sys_clk) disable iff (!nrst)
        (step && ctrl.hundredths_enable && !first_done && presc == 13'h1FEF)
        |=> ticks.second_tick && presc == 13'h0000 && first_done)
        else $error("First second not at 8176 edges in hundredths mode");

    AST_HALT_FREEZES: assert property (@(posedge sys_clk) disable iff (!nrst)
        (ctrl.halt && $past(ctrl.halt) && !ctrl.prescaler_clear
         && !$past(ctrl.prescaler_clear))
        |-> presc == $past(presc) && !ticks.second_tick)
        else $error("Time advanced while halted");

    AST_WRITE_LOCK: assert property (@(posedge sys_clk) disable iff (!nrst)
        time_write_enable == ctrl.halt)
        else $error("Write unlock does not follow halt");

    // Gap since the last step while the internal base runs; a counter, as the
    // divider is far too long for a delay range
    logic [15:0] idle_cnt;
    logic [15:0] next_idle_cnt;

    always_comb begin
        next_idle_cnt = idle_cnt + 16'h0001;
        if (stopped || test_mode || step) begin
            next_idle_cnt = 16'h0000;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            idle_cnt <= 16'h0000;
        end else begin
            idle_cnt <= next_idle_cnt;
        end
    end

    AST_RESTART_BOUND: assert property (@(posedge sys_clk) disable iff (!nrst)
        (s_released ##0 !test_mode) |-> idle_cnt < 16'(INT_DIV_CYCLES))
        else $error("First increment later than one time-base period");

    AST_OUT_IGNORES_HALT: assert property (@(posedge sys_clk) disable iff (!nrst)
        (int_tick && ctrl.halt) |=> clkdiv == $past(clkdiv) + 8'h01)
        else $error("Clock output divider stopped by halt");

endmodule : rtcp_prescaler

// [verif/rtcp_pin_tester.sv]
// Purpose: Board tester model that steps the clock pin in external clock test mode
// Assumes: Pulses are timed in sys_clk cycles, three high and three low at the least
// Notes:   Holds the pin low between bursts so the prescaler sees no stray edge
module rtcp_pin_tester (
    // Clock
    input  wire logic sys_clk,
    // Tester drive onto the clock pin
    output logic      pin_drive
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    initial pin_drive = 1'b0;

    // Minimum pulse widths only, so the run stays short; slower pulses add nothing
    task automatic send_pulses(input int count);
        repeat (count) begin
            @(posedge sys_clk);
            pin_drive <= 1'b1;
            repeat (3) @(posedge sys_clk);
            pin_drive <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
    endtask : send_pulses

endmodule : rtcp_pin_tester

// [verif/rtcp_prescaler_tb.sv]
// Purpose: Self-checking bench for the prescaler, halt and external clock test mode
// Assumes: Internal divider shortened to DIV sys_clk cycles per time-base tick
// Notes:   Tick pulses are counted by a monitor; checks compare counts against a base
module rtcp_prescaler_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DIV = 4;

    logic                  sys_clk;
    logic                  nrst;
    rtcp_pkg::rtcp_ctrl_t  ctrl;
    logic                  pin_drive;
    logic                  pin_level;
    logic                  pin_o;
    logic                  pin_oe;
    logic                  twe;
    logic                  tma;
    logic                  p;
    rtcp_pkg::rtcp_ticks_t ticks;
    int                    fail_count;
    int                    cmp_count;
    int                    sec_cnt;
    int                    hun_cnt;
    int                    cyc;
    int                    s0;
    int                    h0;
    int                    i;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin level: device drives when enabled, tester otherwise
    assign pin_level = pin_oe ? pin_o : pin_drive;

    rtcp_prescaler #(.INT_DIV_CYCLES(DIV)) uut (
        .sys_clk          (sys_clk),
        .nrst             (nrst),
        .ctrl             (ctrl),
        .clock_out_pin_i  (pin_level),
        .clock_out_pin_o  (pin_o),
        .clock_out_pin_oe (pin_oe),
        .time_write_enable(twe),
        .test_mode_active (tma),
        .ticks            (ticks)
    );

    rtcp_pin_tester tester (
        .sys_clk  (sys_clk),
        .pin_drive(pin_drive)
    );

    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (ticks.second_tick === 1'b1) sec_cnt <= sec_cnt + 1;
        if (ticks.hundredth_tick === 1'b1) hun_cnt <= hun_cnt + 1;
        if (cyc == 95000) begin
            $display("ERROR %0t: timeout", $time);
            fail_count++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_cyc

    task automatic set_ctrl(input logic [6:0] v);
        @(posedge sys_clk);
        ctrl <= v;
        #1;
    endtask : set_ctrl

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        ctrl = 7'h00;
        fail_count = 0;
        cmp_count = 0;
        sec_cnt = 0;
        hun_cnt = 0;
        cyc = 0;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        wait_cyc(1);
        check(ticks, 2'h0, "ticks after reset");
        check(pin_oe, 1'b1, "pin driven after reset");
        $display("Test reset done");

        // Enter test mode halted, clear the prescaler, release halt
        set_ctrl(7'h5F);
        check(tma, 1'b1, "test mode active");
        check(pin_oe, 1'b0, "pin turned input");
        check(twe, 1'b1, "time writable in halt");
        set_ctrl(7'h7F);
        wait_cyc(2);
        set_ctrl(7'h5F);
        s0 = sec_cnt;
        h0 = hun_cnt;
        tester.send_pulses(30);
        wait_cyc(4);
        check(sec_cnt - s0 + hun_cnt - h0, 0, "no ticks while halted");
        set_ctrl(7'h1F);
        check(twe, 1'b0, "time locked when running");
        tester.send_pulses(79);
        wait_cyc(4);
        check(hun_cnt - h0, 0, "no hundredth before 80 edges");
        tester.send_pulses(1);
        wait_cyc(4);
        check(hun_cnt - h0, 1, "first hundredth at 80 edges");
        tester.send_pulses(8095);
        wait_cyc(4);
        check(sec_cnt - s0, 0, "no second before 8176 edges");
        tester.send_pulses(1);
        wait_cyc(4);
        check(sec_cnt - s0, 1, "first second at 8176 edges");
        h0 = hun_cnt;
        tester.send_pulses(95);
        wait_cyc(4);
        check(hun_cnt - h0, 0, "no dithered hundredth before 96 edges");
        tester.send_pulses(1);
        wait_cyc(4);
        check(hun_cnt - h0, 1, "first dithered hundredth at 96 edges");
        $display("Test external clock done");

        // Halt in test mode freezes counting
        set_ctrl(7'h5F);
        s0 = sec_cnt;
        h0 = hun_cnt;
        tester.send_pulses(100);
        wait_cyc(4);
        check(sec_cnt - s0 + hun_cnt - h0, 0, "halt stops test mode counting");
        $display("Test halt done");

        // Leave test mode halted; clock output still runs
        set_ctrl(7'h47);
        check(pin_oe, 1'b1, "pin back to output");
        check(tma, 1'b0, "test mode left");
        set_ctrl(7'h49);
        check(pin_oe, 1'b1, "pin output when select leaves 111");
        check(tma, 1'b0, "no test mode when select leaves 111");
        p = pin_o;
        i = 0;
        while (pin_o === p && i < 40) begin
            wait_cyc(1);
            i++;
        end
        check(pin_o !== p, 1'b1, "clock output toggles while halted");
        $display("Test clock output done");

        // Internal time base from a cleared halt
        set_ctrl(7'h60);
        wait_cyc(2);
        set_ctrl(7'h40);
        set_ctrl(7'h00);
        s0 = sec_cnt;
        h0 = hun_cnt;
        wait_cyc(8192 * DIV - 8);
        check(sec_cnt - s0, 0, "no early internal second");
        wait_cyc(16);
        check(sec_cnt - s0, 1, "internal second after 8192 ticks");
        check(hun_cnt - h0, 0, "no hundredths when disabled");
        $display("Test internal time base done");
        report_and_stop();
    end

endmodule : rtcp_prescaler_tb
